// *** fsotc_pkg.sv ***
// Constants shared by the feature-set host controller and its helpers.
// Assumes an 8-bit asynchronous flash bus and a 100 MHz system clock.
package fsotc_pkg;

  // Flash command bytes.
  localparam logic [7:0] CMD_SET_FEAT  = 8'hEF;
  localparam logic [7:0] CMD_GET_FEAT  = 8'hEE;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_PROG      = 8'h80;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;
  localparam logic [7:0] CMD_RESET     = 8'hFF;

  // Feature addresses and mode values.
  localparam logic [7:0] FA_MODE       = 8'h90;
  localparam logic [7:0] FA_LOCK       = 8'hA0;
  localparam logic [7:0] MODE_NORMAL   = 8'h00;
  localparam logic [7:0] MODE_OTP      = 8'h01;
  localparam logic [7:0] MODE_OTP_PROT = 8'h03;
  localparam logic [7:0] LOCK_RESET    = 8'h38;
  localparam logic [7:0] LOCK_RSVD_MSK = 8'hC0;
  localparam int         LOCK_SOLID    = 0;

  // Secure page window and partial program budget.
  localparam logic [7:0] OTP_PAGE_LO   = 8'h02;
  localparam logic [7:0] OTP_PAGE_HI   = 8'h1F;
  localparam logic [3:0] OTP_PROG_MAX  = 4'h8;
  localparam int         ADDR_CYCLES   = 4;

  // Software register offsets (byte addresses).
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_FADDR     = 8'h04;
  localparam logic [7:0] REG_PARAM     = 8'h08;
  localparam logic [7:0] REG_PAGE      = 8'h0C;
  localparam logic [7:0] REG_RESULT    = 8'h10;
  localparam logic [7:0] REG_DEVSTAT   = 8'h14;

  // Timing: clock period and busy-flag settle time.
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         T_WB_NS       = 100;
  localparam int         WB_CYC        = (T_WB_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;

  // Software operations written to the command register.
  typedef enum logic [3:0] {
    OP_SET_FEAT    = 4'h0,
    OP_GET_FEAT    = 4'h1,
    OP_OTP_ENTER   = 4'h2,
    OP_OTP_EXIT    = 4'h3,
    OP_OTP_PROTECT = 4'h4,
    OP_OTP_PROG    = 4'h5,
    OP_RESET       = 4'h6
  } fsotc_op_t;

  // Kinds of sequence step.
  typedef enum logic [2:0] {
    STEP_CMD, STEP_ADDR, STEP_WR, STEP_RD, STEP_STAT, STEP_WAIT, STEP_END
  } fsotc_step_t;

  // Kinds of single bus cycle.
  typedef enum logic [1:0] {
    CYC_CMD, CYC_ADDR, CYC_WR, CYC_RD
  } fsotc_cyc_t;

endpackage : fsotc_pkg

// *** fsotc_rst_sync.sv ***
// Reset release synchroniser for the feature-set host controller.
// Assumes an active-low asynchronous reset from outside the clock domain.
`timescale 1ns/1ps
module fsotc_rst_sync (
  input  wire logic clk_in,    // system clock
  input  wire logic rst_b_in,  // raw reset, active low
  output logic      rst_b_out  // synchronised reset, active low
);
  logic meta_r;

  // Assertion is immediate; release waits two edges to avoid metastability.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r    <= 1'b0;
      rst_b_out <= 1'b0;
    end else begin
      meta_r    <= 1'b1;
      rst_b_out <= meta_r;
    end
  end
endmodule : fsotc_rst_sync

// *** fsotc_pin_cycle.sv ***
// One command, address, data-in or data-out cycle on the flash pins.
// Assumes the caller holds chip enable low and starts one cycle at a time.
`timescale 1ns/1ps
module fsotc_pin_cycle #(
  parameter int SETUP = 2,  // cycles before the strobe falls
  parameter int PULSE = 4,  // cycles the strobe stays low
  parameter int HOLD  = 2   // cycles after the strobe rises
) (
  input  wire logic       clk_in,      // system clock
  input  wire logic       rst_b_in,    // synchronised reset, active low
  input  wire logic       start_in,    // pulse: begin a cycle
  input  wire logic [1:0] kind_in,     // fsotc_cyc_t of the cycle
  input  wire logic [7:0] byte_in,     // byte to drive
  input  wire logic [7:0] io_in,       // raw data pins
  output logic            cle_out,     // command latch enable
  output logic            ale_out,     // address latch enable
  output logic            we_b_out,    // write strobe, active low
  output logic            re_b_out,    // read strobe, active low
  output logic [7:0]      io_out,      // data pins driven value
  output logic            io_oe_out,   // high while driving data pins
  output logic            done_out,    // pulse: cycle finished
  output logic [7:0]      rd_byte_out  // byte captured on a read
);
  localparam int TOTAL = SETUP + PULSE + HOLD;
  localparam int CW    = $clog2(TOTAL + 1);

  // A strobe shorter than three clocks ends before the synchronised pin
  // value is available, so such timing is refused at elaboration.
  if (PULSE < 3 || SETUP < 1 || HOLD < 1) begin : g_bad_timing
    $error("pin cycle timing cannot cover the input synchroniser");
  end

  logic          busy_r;
  logic [CW-1:0] cnt_r;
  logic [1:0]    kind_r;
  logic [7:0]    io_meta_r;
  logic [7:0]    io_sync_r;

  wire strobe_w  = busy_r && cnt_r >= CW'(SETUP) && cnt_r < CW'(SETUP + PULSE);
  wire capture_w = busy_r && cnt_r == CW'(SETUP + PULSE - 1);
  wire last_w    = busy_r && cnt_r == CW'(TOTAL - 1);
  wire is_rd_w   = kind_r == fsotc_pkg::CYC_RD;

  assign cle_out   = busy_r && kind_r == fsotc_pkg::CYC_CMD;
  assign ale_out   = busy_r && kind_r == fsotc_pkg::CYC_ADDR;
  assign we_b_out  = !(strobe_w && !is_rd_w);
  assign re_b_out  = !(strobe_w && is_rd_w);
  assign io_oe_out = busy_r && !is_rd_w;
  assign done_out  = last_w;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_r      <= 1'b0;
      cnt_r       <= '0;
      kind_r      <= 2'h0;
      io_out      <= 8'h00;
      io_meta_r   <= 8'h00;
      io_sync_r   <= 8'h00;
      rd_byte_out <= 8'h00;
    end else begin
      io_meta_r <= io_in;
      io_sync_r <= io_meta_r;
      if (start_in && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r  <= '0;
        kind_r <= kind_in;
        io_out <= byte_in;
      end else if (last_w) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + CW'(1);
      end
      // Read data is sampled late in the strobe so the two-stage pin
      // synchroniser has carried a settled value.
      if (capture_w && is_rd_w)
        rd_byte_out <= io_sync_r;
    end
  end
endmodule : fsotc_pin_cycle

// *** fsotc_host.sv ***
// Host controller that drives feature set, feature get and secure-page
// operations into an asynchronous 8-bit flash over its pins.
// Assumes a 100 MHz clock and a plain software register port.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module fsotc_host (
  input  wire logic        clk_sys_in,   // system clock, 100 MHz
  input  wire logic        rst_b_in,     // reset, active low, asynchronous
  input  wire logic [7:0]  addr_in,      // register byte address
  input  wire logic [31:0] wdata_in,     // register write data
  input  wire logic        wr_in,        // write strobe
  input  wire logic        rd_in,        // read strobe
  output logic      [31:0] rdata_out,    // read data, cycle after rd_in
  output logic             ce_b_out,     // flash chip enable, active low
  output logic             cle_out,      // flash command latch enable
  output logic             ale_out,      // flash address latch enable
  output logic             we_b_out,     // flash write strobe, active low
  output logic             re_b_out,     // flash read strobe, active low
  output logic             wp_b_out,     // flash write protect, active low
  output logic      [7:0]  io_out,       // flash data pins, driven value
  output logic             io_oe_out,    // high while driving data pins
  input  wire logic [7:0]  io_in,        // flash data pins, sensed value
  input  wire logic        rb_b_in       // flash ready/busy, low is busy
);
  logic rst_b;

  fsotc_rst_sync u_rst (
    .clk_in    (clk_sys_in),
    .rst_b_in  (rst_b_in),
    .rst_b_out (rst_b)
  );

  typedef enum logic [2:0] {
    ST_IDLE, ST_STEP, ST_BUS, ST_WB, ST_RB
  } fsotc_state_t;

  localparam int WBW = $clog2(fsotc_pkg::WB_CYC + 1);

  fsotc_state_t  state_r;
  logic [4:0]    idx_r;
  logic [3:0]    op_r;
  logic [7:0]    faddr_r;
  logic [31:0]   param_r;
  logic [7:0]    page_r;
  logic [31:0]   result_r;
  logic [7:0]    stat_r;
  logic [7:0]    mode_r;
  logic [7:0]    lock_r;
  logic          err_r;
  logic [1:0]    rd_cnt_r;
  logic [WBW-1:0] wb_cnt_r;
  logic          rb_meta_r;
  logic          rb_sync_r;
  logic          start_r;
  logic [1:0]    kind_r;
  logic [7:0]    byte_r;
  logic [3:0]    prog_cnt_r [0:31];
  logic          cyc_done;
  logic [7:0]    cyc_rd;

  // Sequence step for an operation: step kind and the byte it carries.
  function automatic logic [10:0] step_of(input logic [3:0] op,
                                          input logic [4:0] i,
                                          input logic [7:0] fa,
                                          input logic [31:0] pb,
                                          input logic [7:0] pg);
    logic [2:0] k;
    logic [7:0] b;
    k = fsotc_pkg::STEP_END;
    b = 8'h00;
    if (op == fsotc_pkg::OP_GET_FEAT) begin
      if (i == 5'd0) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_GET_FEAT; end
      else if (i == 5'd1) begin k = fsotc_pkg::STEP_ADDR; b = fa; end
      else if (i == 5'd2) k = fsotc_pkg::STEP_WAIT;
      else if (i == 5'd3) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_STATUS; end
      else if (i == 5'd4) k = fsotc_pkg::STEP_STAT;
      else if (i == 5'd5) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_READ; end
      else if (i <= 5'd9) k = fsotc_pkg::STEP_RD;
    end else if (op == fsotc_pkg::OP_OTP_PROG) begin
      if (i == 5'd0) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_PROG; end
      else if (i <= 5'(fsotc_pkg::ADDR_CYCLES)) begin
        k = fsotc_pkg::STEP_ADDR;
        b = (i == 5'd3) ? pg : 8'h00;
      end else if (i <= 5'd8) begin
        k = fsotc_pkg::STEP_WR;
        b = pb[8*(i-5'd5) +: 8];
      end
      else if (i == 5'd9) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_PROG_GO; end
      else if (i == 5'd10) k = fsotc_pkg::STEP_WAIT;
      else if (i == 5'd11) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_STATUS; end
      else if (i == 5'd12) k = fsotc_pkg::STEP_STAT;
    end else if (op == fsotc_pkg::OP_RESET) begin
      if (i == 5'd0) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_RESET; end
      else if (i == 5'd1) k = fsotc_pkg::STEP_WAIT;
      else if (i == 5'd2) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_STATUS; end
      else if (i == 5'd3) k = fsotc_pkg::STEP_STAT;
    end else begin
      if (i == 5'd0) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_SET_FEAT; end
      else if (i == 5'd1) begin k = fsotc_pkg::STEP_ADDR; b = fa; end
      else if (i <= 5'd5) begin k = fsotc_pkg::STEP_WR; b = pb[8*(i-5'd2) +: 8]; end
      else if (i == 5'd6) k = fsotc_pkg::STEP_WAIT;
      else if (i == 5'd7) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_STATUS; end
      else if (i == 5'd8) k = fsotc_pkg::STEP_STAT;
      else if (op == fsotc_pkg::OP_OTP_PROTECT) begin
        if (i == 5'd9) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_PROG; end
        else if (i <= 5'd13) k = fsotc_pkg::STEP_ADDR;
        else if (i == 5'd14) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_PROG_GO; end
        else if (i == 5'd15) k = fsotc_pkg::STEP_WAIT;
        else if (i == 5'd16) begin k = fsotc_pkg::STEP_CMD; b = fsotc_pkg::CMD_STATUS; end
        else if (i == 5'd17) k = fsotc_pkg::STEP_STAT;
      end
    end
    return {k, b};
  endfunction : step_of

  // Parameter bytes fixed by the mode operations.
  // entry, exit, protect
  wire [31:0] pb_w =
    (op_r == fsotc_pkg::OP_OTP_ENTER)   ? {24'h0, fsotc_pkg::MODE_OTP} :
    (op_r == fsotc_pkg::OP_OTP_EXIT)    ? {24'h0, fsotc_pkg::MODE_NORMAL} :
    (op_r == fsotc_pkg::OP_OTP_PROTECT) ? {24'h0, fsotc_pkg::MODE_OTP_PROT} :
    param_r;
  wire [7:0]  fa_w = (op_r == fsotc_pkg::OP_SET_FEAT ||
                      op_r == fsotc_pkg::OP_GET_FEAT) ? faddr_r
                                                      : fsotc_pkg::FA_MODE;
  wire [10:0] step_w = step_of(op_r, idx_r, fa_w, pb_w, page_r);
  wire [2:0]  skind_w = step_w[10:8];
  wire [7:0]  sbyte_w = step_w[7:0];

  // Checks on a software request before anything reaches the pins.
  wire [3:0]  req_op_w  = wdata_in[3:0];
  wire        cmd_wr_w  = wr_in && addr_in == fsotc_pkg::REG_CMD;
  wire        fa_ok_w   = faddr_r == fsotc_pkg::FA_MODE ||
                          faddr_r == fsotc_pkg::FA_LOCK;
  // reserved lock bits, solid lock held
  wire        lock_ok_w = faddr_r != fsotc_pkg::FA_LOCK ||
                          ((param_r[7:0] & fsotc_pkg::LOCK_RSVD_MSK) == 8'h00
                           && !lock_r[fsotc_pkg::LOCK_SOLID]);
  // page window, OTP mode only (refused in normal or protected mode), budget
  wire        pg_ok_w   = page_r >= fsotc_pkg::OTP_PAGE_LO &&
                          page_r <= fsotc_pkg::OTP_PAGE_HI &&
                          mode_r == fsotc_pkg::MODE_OTP &&
                          prog_cnt_r[page_r[4:0]] < fsotc_pkg::OTP_PROG_MAX;
  wire        req_ok_w  =
    (req_op_w == fsotc_pkg::OP_SET_FEAT)    ? (fa_ok_w && lock_ok_w) :
    (req_op_w == fsotc_pkg::OP_GET_FEAT)    ? fa_ok_w :
    (req_op_w == fsotc_pkg::OP_OTP_PROG)    ? pg_ok_w :
    (req_op_w <= fsotc_pkg::OP_RESET);
  wire        accept_w  = cmd_wr_w && state_r == ST_IDLE && req_ok_w;
  wire        refuse_w  = cmd_wr_w && !(state_r == ST_IDLE && req_ok_w);
  wire        busy_w    = state_r != ST_IDLE;
  wire        finish_w  = state_r == ST_STEP && skind_w == fsotc_pkg::STEP_END;

  // Register read decode.
  wire [31:0] rd_mux_w =
    (addr_in == fsotc_pkg::REG_CMD)     ? {8'h0, lock_r, mode_r, 5'h0,
                                           err_r, rb_sync_r, busy_w} :
    (addr_in == fsotc_pkg::REG_FADDR)   ? {24'h0, faddr_r} :
    (addr_in == fsotc_pkg::REG_PARAM)   ? param_r :
    (addr_in == fsotc_pkg::REG_PAGE)    ? {24'h0, page_r} :
    (addr_in == fsotc_pkg::REG_RESULT)  ? result_r :
    (addr_in == fsotc_pkg::REG_DEVSTAT) ? {24'h0, stat_r} : 32'h0;

  assign ce_b_out = !busy_w;
  assign wp_b_out = 1'b1;

  fsotc_pin_cycle u_cyc (
    .clk_in      (clk_sys_in),
    .rst_b_in    (rst_b),
    .start_in    (start_r),
    .kind_in     (kind_r),
    .byte_in     (byte_r),
    .io_in       (io_in),
    .cle_out     (cle_out),
    .ale_out     (ale_out),
    .we_b_out    (we_b_out),
    .re_b_out    (re_b_out),
    .io_out      (io_out),
    .io_oe_out   (io_oe_out),
    .done_out    (cyc_done),
    .rd_byte_out (cyc_rd)
  );

  // Software-facing registers.
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      faddr_r   <= 8'h00;
      param_r   <= 32'h0;
      page_r    <= 8'h00;
      rdata_out <= 32'h0;
      err_r     <= 1'b0;
    end else begin
      rdata_out <= rd_in ? rd_mux_w : 32'h0;
      if (wr_in && !busy_w) begin
        if (addr_in == fsotc_pkg::REG_FADDR)
          faddr_r <= wdata_in[7:0];
        else if (addr_in == fsotc_pkg::REG_PARAM)
          param_r <= wdata_in;
        else if (addr_in == fsotc_pkg::REG_PAGE)
          page_r <= wdata_in[7:0];
      end
      if (refuse_w)
        err_r <= 1'b1;
      else if (accept_w)
        err_r <= 1'b0;
    end
  end

  // Ready/busy pin synchroniser.
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      rb_meta_r <= 1'b0;
      rb_sync_r <= 1'b0;
    end else begin
      rb_meta_r <= rb_b_in;
      rb_sync_r <= rb_meta_r;
    end
  end

  // Sequencer: walks the step list one bus cycle or wait at a time.
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      state_r  <= ST_IDLE;
      idx_r    <= 5'h0;
      op_r     <= 4'h0;
      start_r  <= 1'b0;
      kind_r   <= 2'h0;
      byte_r   <= 8'h00;
      wb_cnt_r <= '0;
      rd_cnt_r <= 2'h0;
      result_r <= 32'h0;
      stat_r   <= 8'h00;
    end else begin
      start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (accept_w) begin
            op_r     <= req_op_w;
            idx_r    <= 5'h0;
            rd_cnt_r <= 2'h0;
            state_r  <= ST_STEP;
          end
        end
        ST_STEP: begin
          byte_r <= sbyte_w;
          if (skind_w == fsotc_pkg::STEP_END) begin
            state_r <= ST_IDLE;
          end else if (skind_w == fsotc_pkg::STEP_WAIT) begin
            wb_cnt_r <= '0;
            state_r  <= ST_WB;
          end else begin
            start_r <= 1'b1;
            state_r <= ST_BUS;
            if (skind_w == fsotc_pkg::STEP_CMD)
              kind_r <= fsotc_pkg::CYC_CMD;
            else if (skind_w == fsotc_pkg::STEP_ADDR)
              kind_r <= fsotc_pkg::CYC_ADDR;
            else if (skind_w == fsotc_pkg::STEP_WR)
              kind_r <= fsotc_pkg::CYC_WR;
            else
              kind_r <= fsotc_pkg::CYC_RD;
          end
        end
        ST_BUS: begin
          if (cyc_done) begin
            // status byte to stat_r; read bytes fill result_r, low byte first
            if (skind_w == fsotc_pkg::STEP_STAT) begin
              stat_r <= cyc_rd;
            end else if (skind_w == fsotc_pkg::STEP_RD) begin
              result_r[8*rd_cnt_r +: 8] <= cyc_rd;
              rd_cnt_r <= rd_cnt_r + 2'h1;
            end
            idx_r   <= idx_r + 5'h1;
            state_r <= ST_STEP;
          end
        end
        ST_WB: begin
          if (wb_cnt_r == WBW'(fsotc_pkg::WB_CYC))
            state_r <= ST_RB;
          else
            wb_cnt_r <= wb_cnt_r + WBW'(1);
        end
        default: begin
          // ready seen on the busy pin
          if (rb_sync_r) begin
            idx_r   <= idx_r + 5'h1;
            state_r <= ST_STEP;
          end
        end
      endcase
    end
  end

  // Shadows of the flash feature state, kept for software and checks.
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= fsotc_pkg::MODE_NORMAL;
      lock_r <= fsotc_pkg::LOCK_RESET;
    end else if (finish_w) begin
      // flash reset leaves shadows alone; reserved writes ignored
      if (op_r == fsotc_pkg::OP_SET_FEAT && faddr_r == fsotc_pkg::FA_MODE)
        mode_r <= param_r[7:0];
      else if (op_r == fsotc_pkg::OP_SET_FEAT &&
               faddr_r == fsotc_pkg::FA_LOCK)
        lock_r <= param_r[7:0];
      else if (op_r == fsotc_pkg::OP_OTP_ENTER)
        mode_r <= fsotc_pkg::MODE_OTP;
      else if (op_r == fsotc_pkg::OP_OTP_EXIT)
        mode_r <= fsotc_pkg::MODE_NORMAL;
      else if (op_r == fsotc_pkg::OP_OTP_PROTECT)
        mode_r <= fsotc_pkg::MODE_OTP_PROT;
      else if (op_r == fsotc_pkg::OP_GET_FEAT &&
               faddr_r == fsotc_pkg::FA_MODE)
        mode_r <= result_r[7:0];
      else if (op_r == fsotc_pkg::OP_GET_FEAT &&
               faddr_r == fsotc_pkg::FA_LOCK)
        lock_r <= result_r[7:0];
    end
  end

  // partial program count per secure page
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < 32; p++)
        prog_cnt_r[p] <= 4'h0;
    end else if (accept_w && req_op_w == fsotc_pkg::OP_OTP_PROG) begin
      prog_cnt_r[page_r[4:0]] <= prog_cnt_r[page_r[4:0]] + 4'h1;
    end
  end
endmodule : fsotc_host

// *** fsotc_host_asserts.sv ***
// Pin and register port timing checks for the host controller.
// Assumes it is bound onto fsotc_host with unrenamed ports.
`timescale 1ns/1ps
module fsotc_host_asserts (
  input wire logic        clk_sys_in, // clock
  input wire logic        rst_b_in,   // reset
  input wire logic        wr_in,      // wr
  input wire logic        rd_in,      // rd
  input wire logic [7:0]  addr_in,    // addr
  input wire logic [31:0] rdata_out,  // rdata
  input wire logic        ce_b_out,   // ce
  input wire logic        cle_out,    // cle
  input wire logic        ale_out,    // ale
  input wire logic        we_b_out,   // we
  input wire logic        re_b_out,   // re
  input wire logic [7:0]  io_out,     // io
  input wire logic        io_oe_out   // oe
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_cmd;
    (cle_out && we_b_out)[*2] ##1 (cle_out && !we_b_out)[*4]
    ##1 (cle_out && we_b_out)[*2] ##1 !cle_out;
  endsequence
  sequence s_adr;
    (ale_out && we_b_out)[*2] ##1 (ale_out && !we_b_out)[*4]
    ##1 (ale_out && we_b_out)[*2] ##1 !ale_out;
  endsequence
  chk_cmd_cycle: assert property ($rose(cle_out) |-> s_cmd)
    else $error("command cycle shape wrong");
  chk_addr_cycle: assert property ($rose(ale_out) |-> s_adr)
    else $error("address cycle shape wrong");
  chk_latch_excl: assert property (!(cle_out && ale_out))
    else $error("both latch enables high");
  chk_read_pulse: assert property ($fell(re_b_out) |->
    (!re_b_out)[*4] ##1 re_b_out)
    else $error("read strobe length wrong");
  chk_read_float: assert property (!re_b_out |->
    !io_oe_out && !cle_out && !ale_out)
    else $error("host drives during read");
  chk_write_hold: assert property (!we_b_out |->
    io_oe_out && $stable(io_out) && !ce_b_out)
    else $error("write data not held");
  chk_ce_start: assert property ($fell(ce_b_out) |->
    $past(wr_in) && $past(addr_in) == fsotc_pkg::REG_CMD)
    else $error("chip enable without command");
  chk_rdata_idle: assert property (!$past(rd_in) |->
    rdata_out == 32'h0)
    else $error("read data outside slot");
endmodule : fsotc_host_asserts
bind fsotc_host fsotc_host_asserts chk_i (.clk_sys_in, .rst_b_in,
  .wr_in, .rd_in, .addr_in, .rdata_out, .ce_b_out, .cle_out,
  .ale_out, .we_b_out, .re_b_out, .io_out, .io_oe_out);

// *** fsotc_flash_model.sv ***
// Behavioural flash device with the two feature registers.
// Assumes one host on the pins; busy time is short or long.
`timescale 1ns/1ps
module fsotc_flash_model (
  input  wire logic       ce_b_in,  // ce
  input  wire logic       cle_in,   // cle
  input  wire logic       ale_in,   // ale
  input  wire logic       we_b_in,  // we
  input  wire logic       re_b_in,  // re
  input  wire logic       pt_in,    // protect_enable_pin
  input  wire logic       slow_in,  // long busy
  input  wire logic [7:0] io_in,    // bus
  output logic      [7:0] io_out,   // drive
  output logic            rb_b_out  // ready
);
  logic [31:0] mode_r = 32'h0, lock_r = 32'h38, par, sel;
  logic [7:0]  cmd_r, fa_r, dout = 8'h00;
  logic        stat = 1'b0;
  int          n, rn;
  event        go;
  initial rb_b_out = 1'b1;
  assign sel = fa_r == 8'h90 ? mode_r : fa_r == 8'hA0 ? lock_r : 32'h0;
  assign io_out = (!re_b_in && !ce_b_in) ? dout : ~dout;
  always @(posedge we_b_in) if (!ce_b_in) begin
    if (cle_in) begin
      stat = io_in == 8'h70;
      if (io_in != 8'h70 && io_in != 8'h00) cmd_r = io_in;
      if (io_in == 8'hFF || io_in == 8'h10) ->go;
    end else if (ale_in) begin
      fa_r = io_in;
      n = 0;
      rn = 0;
      if (cmd_r == 8'hEE) ->go;
    end else begin
      par[8*n+:8] = io_in;
      n++;
      // four bytes into the addressed register
      if (cmd_r == 8'hEF && n == 4) begin
        if (fa_r == 8'h90) mode_r = par;
        if (fa_r == 8'hA0 && pt_in && !lock_r[0]) lock_r = par & 32'h3F;
        ->go;
      end
    end
  end
  // status byte or feature bytes in order
  always @(negedge re_b_in) if (!ce_b_in) begin
    if (stat) dout = {1'b1, rb_b_out, 6'h00};
    else begin
      dout = sel[8*rn+:8];
      rn++;
    end
  end
  always @go begin
    rb_b_out = 1'b0;
    #(slow_in ? 2000 : 50) rb_b_out = 1'b1;
  end
endmodule : fsotc_flash_model

// *** tb_feature_set_otp_control.sv ***
// Self-checking bench: host controller against the flash model.
// Assumes the register map and op codes of the host controller.
`timescale 1ns/1ps
module tb_feature_set_otp_control;
  logic clk_sys_in = 0, rst_b_in = 0, wr = 0, rd = 0, slow = 0, bad;
  logic ce_b, cle, ale, we_b, re_b, oe, rb_b, wp;
  logic [7:0]  adr = 8'h00, hio, fio, bus, pg;
  logic [31:0] wd = 32'h0, rdat, got, v, seed = 32'd22844;
  int err_count = 0, num_checks = 0, mode = 0, lock = 8'h38, i, k;
  always #5 clk_sys_in = ~clk_sys_in;
  assign bus = oe ? hio : fio;
  fsotc_host fsotc_host_i (.clk_sys_in, .rst_b_in, .addr_in(adr),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdat),
    .ce_b_out(ce_b), .cle_out(cle), .ale_out(ale), .we_b_out(we_b),
    .re_b_out(re_b), .wp_b_out(wp), .io_out(hio), .io_oe_out(oe),
    .io_in(bus), .rb_b_in(rb_b));
  fsotc_flash_model fsotc_flash_model_i (.ce_b_in(ce_b), .cle_in(cle),
    .ale_in(ale), .we_b_in(we_b), .re_b_in(re_b), .pt_in(1'b1),
    .slow_in(slow), .io_in(bus), .io_out(fio), .rb_b_out(rb_b));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge clk_sys_in);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    got = rdat;
  endtask : rreg
  // Polls busy with a bound so a hung operation ends the run.
  task automatic op(input logic [3:0] o, input logic e);
    wreg(8'h00, {28'h0, o});
    for (i = 0; i < 5000; i++) begin
      rreg(8'h00);
      if (got[0] === 1'b0) break;
    end
    if (i == 5000) begin
      err_count++;
      final_report();
    end else begin
      check("status", got & 32'h00FFFF04,
            {8'h00, lock[7:0], mode[7:0], 5'h00, e, 2'h0});
    end
  endtask : op
  task automatic getf(input logic [7:0] fa, input logic [31:0] e);
    wreg(8'h04, {24'h0, fa});
    op(4'h1, 1'b0);
    rreg(8'h10);
    check("feature", got, e);
    rreg(8'h14);
    check("devstat", got, 32'hC0);
  endtask : getf
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check("wp", wp, 32'h1);
    getf(8'hA0, 32'h38);
    rreg(8'h3C);
    check("unmapped", got, 32'h0);
    wreg(8'h04, 32'h55);
    op(4'h0, 1'b1);
    for (k = 0; k < 4; k++) begin
      v = xs() & 32'h3E;
      if (k == 0) v = v | 32'hC0;
      if (k == 2) v = v | 32'h01;
      bad = v[7:6] != 2'b00 || lock[0];
      if (!bad) lock = v;
      wreg(8'h04, 32'hA0);
      wreg(8'h08, v);
      op(4'h0, bad);
      getf(8'hA0, lock);
    end
    mode = 1;
    op(4'h2, 1'b0);
    for (k = 0; k < 10; k++) begin
      pg = k == 0 ? 8'h01 : 8'h1F;
      wreg(8'h0C, {24'h0, pg});
      wreg(8'h08, xs());
      slow <= 1'(xs());
      op(4'h5, k == 0 || k == 9);
    end
    op(4'h6, 1'b0);
    getf(8'h90, 32'h1);
    mode = 3;
    op(4'h4, 1'b0);
    getf(8'h90, 32'h3);
    wreg(8'h0C, 32'h2);
    op(4'h5, 1'b1);
    mode = 0;
    op(4'h3, 1'b0);
    op(4'h7, 1'b1);
    final_report();
  end
endmodule : tb_feature_set_otp_control
